/* File: rtl/l2sb_ctrl.sv */
// Summary of operation
// - buffered writes stay invisible to memory until their slot drains.
// - a sync request drains every pending slot to memory.
// - with auto drain enabled a slot drains after 256 cycles resident.
// - only Normal-memory writes are held; others drain at once.
// - prefetching is active when either enable bit 29 or 28 is high.
// - control bits 4..0 plus one give how many lines ahead the prefetch goes.
// - no prefetch linefill leaves the 4 KB page of its trigger.
// - the page limit also holds for an offset of 23.
`timescale 1ns/1ps
`default_nettype none
module l2sb_ctrl
  import l2sb_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // configuration
  input wire logic [31:0] i_pf_ctrl,
  input wire logic i_auto_drain_en,
  // core write side
  input wire logic i_wr_valid,
  input wire logic [ADDR_W-1:0] i_wr_addr,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic i_wr_normal,
  output logic o_wr_ready,
  // cache sync
  input wire logic i_sync_req,
  output logic o_sync_busy,
  output logic o_sync_done,
  // read miss trigger
  input wire logic i_miss_valid,
  input wire logic [ADDR_W-1:0] i_miss_addr,
  // memory write port
  output logic o_mem_wvalid,
  output logic [ADDR_W-1:0] o_mem_waddr,
  output logic [DATA_W-1:0] o_mem_wdata,
  input wire logic i_mem_wready,
  input wire logic i_mem_wack,
  // prefetch linefill port
  output logic o_pf_valid,
  output logic [ADDR_W-1:0] o_pf_addr,
  input wire logic i_pf_ready,
  // status
  output logic o_sb_empty
);
  // ==========================================================================
  // slot storage
  logic [SLOTS-1:0] vld_q;
  logic [ADDR_W-1:0] addr_q [SLOTS];
  logic [DATA_W-1:0] data_q [SLOTS];
  logic [RES_W-1:0] age_q [SLOTS];
  logic [SLOTS-1:0] ripe;
  logic [SLOTS-1:0] free_1h;
  logic [SLOTS-1:0] drain_1h;
  logic [SLOTS-1:0] take_1h;
  logic [SLOTS-1:0] pend;
  logic [SLOTS-1:0] urgent_q;
  logic [3:0] outst_q;
  l2sb_state_t state_q;
  logic [SLOT_W-1:0] sel_q;
  logic sync_q;
  logic wr_ready_q;
  logic empty_q;
  logic done_q;

  wire any_free = |(~vld_q);
  wire wr_take = i_wr_valid & wr_ready_q;
  wire issue_fire = (state_q == L2SB_ISSUE) & i_mem_wready;
  wire urgent_in = wr_take & ~i_wr_normal;

  // pick lowest free slot and lowest slot wanting drain
  always_comb begin
    free_1h = '0;
    drain_1h = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (!vld_q[i]) begin
        free_1h = '0;
        free_1h[i] = 1'b1;
      end
      if (pend[i]) begin
        drain_1h = '0;
        drain_1h[i] = 1'b1;
      end
    end
  end

  logic [SLOT_W-1:0] drain_idx;
  always_comb begin
    drain_idx = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (drain_1h[i]) begin
        drain_idx = SLOT_W'(i);
      end
    end
  end

  assign take_1h = wr_take ? free_1h : '0;

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      assign ripe[g] = vld_q[g] & i_auto_drain_en & (age_q[g] >= RES_LIMIT - 9'h001);
      // drain only on sync or ripe or urgent
      assign pend[g] = vld_q[g] & (sync_q | ripe[g] | urgent_q[g]);
      always_ff @(posedge i_clock) begin
        if (i_srst) begin
          age_q[g] <= RES_RESET;
        end else if (take_1h[g]) begin
          age_q[g] <= RES_RESET;
        end else if (vld_q[g] && age_q[g] != RES_LIMIT) begin
          age_q[g] <= age_q[g] + 9'h001;
        end
      end
      always_ff @(posedge i_clock) begin
        if (take_1h[g]) begin
          addr_q[g] <= i_wr_addr;
          data_q[g] <= i_wr_data;
        end
      end
    end
  endgenerate

  wire [SLOTS-1:0] clr_1h = (issue_fire ? (SLOTS'(1) << sel_q) : '0);

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      vld_q <= '0;
      urgent_q <= '0;
    end else begin
      vld_q <= (vld_q & ~clr_1h) | take_1h;
      urgent_q <= (urgent_q & ~clr_1h) | (urgent_in ? take_1h : '0);
    end
  end

  // ==========================================================================
  // drain engine
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_q <= L2SB_IDLE;
      sel_q <= '0;
      o_mem_wvalid <= 1'b0;
      o_mem_waddr <= '0;
      o_mem_wdata <= '0;
    end else begin
      case (state_q)
        L2SB_IDLE: begin
          if (|pend) begin
            state_q <= L2SB_ISSUE;
            sel_q <= drain_idx;
            o_mem_wvalid <= 1'b1;
            o_mem_waddr <= addr_q[drain_idx];
            o_mem_wdata <= data_q[drain_idx];
          end
        end
        L2SB_ISSUE: begin
          if (i_mem_wready) begin
            o_mem_wvalid <= 1'b0;
            state_q <= L2SB_IDLE;
          end
        end
        default: begin
          state_q <= L2SB_IDLE;
        end
      endcase
    end
  end

  // outstanding write acknowledgements
  wire [3:0] outst_d = outst_q + {3'h0, issue_fire} - {3'h0, i_mem_wack & (outst_q != 4'h0)};
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      outst_q <= 4'h0;
    end else begin
      outst_q <= outst_d;
    end
  end

  // ==========================================================================
  // cache sync
  wire all_clear = (vld_q == '0) & (outst_q == 4'h0) & (state_q == L2SB_IDLE) & ~wr_take;
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sync_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (i_sync_req && !sync_q) begin
        sync_q <= 1'b1;
      end else if (sync_q && all_clear) begin
        sync_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end
  assign o_sync_busy = sync_q;
  assign o_sync_done = done_q;

  // writes stall while a sync runs so it terminates
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      wr_ready_q <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      wr_ready_q <= ~sync_q & ~i_sync_req & (vld_q | take_1h) != '1 & ~(wr_take & ~(any_free & ((vld_q | take_1h) != '1)));
      empty_q <= ((vld_q & ~clr_1h) | take_1h) == '0;
    end
  end
  assign o_wr_ready = wr_ready_q;
  assign o_sb_empty = empty_q;

  // ==========================================================================
  // prefetcher
  // either enable bit
  wire pf_on = i_pf_ctrl[PF_EN_HI] | i_pf_ctrl[PF_EN_LO];
  wire [4:0] pf_off = i_pf_ctrl[PF_OFF_HI:PF_OFF_LO];
  wire [PAGE_LSB-LINE_LSB:0] line_sum =
    {1'b0, i_miss_addr[PAGE_LSB-1:LINE_LSB]} + (PAGE_LSB - LINE_LSB + 1)'(pf_off) + 8'h01;
  wire pf_in_page = ~line_sum[PAGE_LSB-LINE_LSB];
  wire pf_hold = o_pf_valid & ~i_pf_ready;
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_pf_valid <= 1'b0;
      o_pf_addr <= '0;
    end else if (!pf_hold) begin
      o_pf_valid <= i_miss_valid & pf_on & pf_in_page;
      o_pf_addr <= {i_miss_addr[ADDR_W-1:PAGE_LSB], line_sum[PAGE_LSB-LINE_LSB-1:0],
                    {LINE_LSB{1'b0}}};
    end
  end

  // ==========================================================================
  // checks
  // page limit
  AST_PF_PAGE: assert property (@(posedge i_clock) disable iff (i_srst)
    $rose(o_pf_valid) |-> o_pf_addr[ADDR_W-1:PAGE_LSB] == $past(i_miss_addr[ADDR_W-1:PAGE_LSB]))
    else $error("prefetch left page");
  AST_PF_OFF: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_miss_valid && !pf_on && !pf_hold) |=> !o_pf_valid)
    else $error("prefetch while disabled");
  AST_SYNC_DONE: assert property (@(posedge i_clock) disable iff (i_srst)
    o_sync_done |-> (vld_q == '0) && (outst_q == 4'h0))
    else $error("sync done early");
  AST_SYNC_DRAIN: assert property (@(posedge i_clock) disable iff (i_srst)
    (sync_q && vld_q != '0 && state_q == L2SB_IDLE) |=> o_mem_wvalid)
    else $error("sync not draining");
  AST_HOLD: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_q == L2SB_IDLE && !sync_q && !i_auto_drain_en && urgent_q == '0) |=> !o_mem_wvalid)
    else $error("drain without cause");
  AST_RIPE: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_q == L2SB_IDLE && |ripe) |=> o_mem_wvalid)
    else $error("ripe slot not drained");
  AST_URGENT: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_q == L2SB_IDLE && |(urgent_q & vld_q)) |=> o_mem_wvalid)
    else $error("device write held");
  AST_PF_OFFSET: assert property (@(posedge i_clock) disable iff (i_srst)
    $rose(o_pf_valid) |-> o_pf_addr[PAGE_LSB-1:LINE_LSB] ==
      7'($past(i_miss_addr[PAGE_LSB-1:LINE_LSB]) + $past(pf_off) + 7'h01))
    else $error("wrong prefetch offset");
endmodule : l2sb_ctrl
`default_nettype wire

/* File: rtl/l2sb_pkg.sv */
package l2sb_pkg;
  // ==========================================================================
  // geometry
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SLOTS = 4;
  localparam int unsigned SLOT_W = 2;
  localparam int unsigned LINE_LSB = 5;
  localparam int unsigned PAGE_LSB = 12;
  // ==========================================================================
  // prefetch control fields
  localparam int unsigned PF_EN_HI = 29;
  localparam int unsigned PF_EN_LO = 28;
  localparam int unsigned PF_OFF_HI = 4;
  localparam int unsigned PF_OFF_LO = 0;
  localparam logic [4:0] PF_OFF_HAZARD = 5'h17;
  // ==========================================================================
  // residency timeout
  localparam int unsigned RESIDENCY_CYCLES = 256;
  localparam int unsigned RES_W = 9;
  localparam logic [RES_W-1:0] RES_LIMIT = RES_W'(RESIDENCY_CYCLES);
  localparam logic [RES_W-1:0] RES_RESET = 9'h000;
  // ==========================================================================
  // drain states
  typedef enum logic [1:0] {L2SB_IDLE, L2SB_ISSUE, L2SB_WAIT} l2sb_state_t;
endpackage : l2sb_pkg

/* File: verification/l2sb_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module l2sb_mem_model (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // write port
  input wire logic i_mem_wvalid,
  input wire logic [31:0] i_mem_waddr,
  input wire logic [31:0] i_mem_wdata,
  output logic o_mem_wready = 1'b0,
  output logic o_mem_wack = 1'b0,
  // linefill port
  input wire logic i_pf_valid,
  output logic o_pf_ready = 1'b0
);
  logic [63:0] wq[$];
  int owed = 0;
  // ==========================================
  // random stalls and late acks
  always @(posedge i_clock) begin
    if (i_mem_wvalid && o_mem_wready && !i_srst) begin
      wq.push_back({i_mem_waddr, i_mem_wdata});
    end
    owed <= i_srst ? 0 : owed + int'(i_mem_wvalid && o_mem_wready) - int'(o_mem_wack);
    o_mem_wack <= !i_srst && owed > int'(o_mem_wack) && $urandom_range(1, 0) == 1;
    o_mem_wready <= !i_srst && $urandom_range(1, 0) == 1;
    o_pf_ready <= !i_srst && $urandom_range(1, 0) == 1;
  end
endmodule : l2sb_mem_model
`default_nettype wire

/* File: verification/test_l2sb_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module test_l2sb_ctrl;
  import l2sb_pkg::*;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic [31:0] pfc = '0;
  logic [31:0] wa = '0;
  logic [31:0] wd = '0;
  logic [31:0] ma = '0;
  logic aen = 1'b0, wv = 1'b0, wn = 1'b0, sreq = 1'b0, mv = 1'b0;
  logic rdy, busy, done, mwv, wrdy, wack, pfv, pfr, sbe;
  logic [31:0] mwa, mwd, pfa;
  logic [63:0] hq[$], eq[$];
  int mismatches = 0;
  int samples_checked = 0;
  always #5 i_clock = ~i_clock;
  l2sb_ctrl dut (.i_clock(i_clock), .i_srst(i_srst), .i_pf_ctrl(pfc), .i_auto_drain_en(aen),
    .i_wr_valid(wv), .i_wr_addr(wa), .i_wr_data(wd), .i_wr_normal(wn), .o_wr_ready(rdy),
    .i_sync_req(sreq), .o_sync_busy(busy), .o_sync_done(done), .i_miss_valid(mv),
    .i_miss_addr(ma), .o_mem_wvalid(mwv), .o_mem_waddr(mwa), .o_mem_wdata(mwd),
    .i_mem_wready(wrdy), .i_mem_wack(wack), .o_pf_valid(pfv), .o_pf_addr(pfa),
    .i_pf_ready(pfr), .o_sb_empty(sbe));
  l2sb_mem_model mem (.i_clock(i_clock), .i_srst(i_srst), .i_mem_wvalid(mwv),
    .i_mem_waddr(mwa), .i_mem_wdata(mwd), .o_mem_wready(wrdy), .o_mem_wack(wack),
    .i_pf_valid(pfv), .o_pf_ready(pfr));
  // ==========================================
  // helpers
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick;
    @(posedge i_clock);
    #1;
  endtask : tick
  task automatic put(input logic [31:0] a, input logic normal);
    int n;
    logic r;
    n = 0;
    wv = 1'b1;
    wa = a;
    wd = $urandom;
    wn = normal;
    if (normal) hq.push_back({a, wd});
    else eq.push_back({a, wd});
    do begin
      r = rdy;
      tick;
      n++;
    end while (!r && n < 50);
    check("write taken", {63'h0, r}, 64'h1);
    wv = 1'b0;
    tick;
  endtask : put
  task automatic drained;
    check("drain count", 64'(mem.wq.size()), 64'(eq.size()));
    while (eq.size() > 0 && mem.wq.size() > 0) begin
      check("drained write", mem.wq.pop_front(), eq.pop_front());
    end
    eq.delete();
  endtask : drained
  task automatic sync_op;
    int n;
    n = 0;
    eq = {eq, hq};
    hq.delete();
    sreq = 1'b1;
    tick;
    sreq = 1'b0;
    check("busy at start", {63'h0, busy}, 64'h1);
    check("ready in sync", {63'h0, rdy}, 64'h0);
    while (done !== 1'b1 && n < 300) begin
      tick;
      n++;
    end
    check("sync done", {63'h0, done}, 64'h1);
    check("acks owed", 64'(mem.owed), 64'h0);
    check("busy at done", {63'h0, busy}, 64'h0);
    check("empty at done", {63'h0, sbe}, 64'h1);
    drained();
    $display("test sync finished");
  endtask : sync_op
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    #200000;
    mismatches++;
    close_out();
  end
  // ==========================================
  // scenarios
  initial begin
    int n, nl;
    logic [4:0] off;
    logic hit;
    logic [31:0] cv, av;
    void'($urandom(32'hb8be));
    repeat (8) tick;
    i_srst = 1'b0;
    tick;
    check("ready after reset", {63'h0, rdy}, 64'h1);
    check("empty after reset", {63'h0, sbe}, 64'h1);
    put(32'h1000_0040, 1'b1);
    put(32'h1000_0080, 1'b1);
    repeat (300) tick;
    check("held writes", 64'(mem.wq.size()), 64'h0);
    check("held not empty", {63'h0, sbe}, 64'h0);
    $display("test held finished");
    sync_op();
    put(32'h2000_0100, 1'b1);
    put(32'h2000_0200, 1'b0);
    repeat (60) tick;
    drained();
    $display("test urgent finished");
    sync_op();
    aen = 1'b1;
    put(32'h3000_0020, 1'b1);
    n = 0;
    while (mwv !== 1'b1 && n < 400) begin
      tick;
      n++;
    end
    check("auto age", 64'(n + 1), 64'(RESIDENCY_CYCLES));
    nl = 0;
    while (mem.wq.size() == 0 && nl < 50) begin
      tick;
      nl++;
    end
    eq = hq;
    hq.delete();
    drained();
    aen = 1'b0;
    $display("test auto finished");
    for (int i = 0; i < 32; i++) begin
      off = (i % 8 < 4) ? PF_OFF_HAZARD : 5'($urandom);
      if (i % 8 >= 4 && off == PF_OFF_HAZARD) off = 5'h0f;
      cv = $urandom;
      cv[29:28] = 2'(i % 4);
      cv[4:0] = off;
      av = $urandom;
      if (i % 8 >= 4) av[11:5] = 7'(127 - int'(off) - (i % 2));
      nl = int'(av[11:5]) + int'(off) + 1;
      hit = (i % 4 != 0) && nl < 128;
      pfc = cv;
      ma = av;
      mv = 1'b1;
      tick;
      mv = 1'b0;
      check("pf issued", {63'h0, pfv}, {63'h0, hit});
      if (hit) check("pf addr", pfa, {ma[31:12], 7'(nl), 5'h0});
      n = 0;
      while (pfv === 1'b1 && n < 50) begin
        tick;
        n++;
      end
    end
    $display("test prefetch finished");
    close_out();
  end
endmodule : test_l2sb_ctrl
`default_nettype wire
